// file: monitor_pkg.sv
// Shared constants of the hardware monitor alert and configuration logic.
// Assumes a single 50 MHz system clock and a synchronous active-low reset.
package monitor_pkg;
   // ==========================================================
   // Register indices behind the address pointer
   localparam logic [7:0] CFG_IDX = 8'h00;
   localparam logic [7:0] ST1_IDX = 8'h01;
   localparam logic [7:0] ST2_IDX = 8'h02;
   localparam logic [7:0] MASK1_IDX = 8'h03;
   localparam logic [7:0] PTR_RESET = 8'h00;
   // ==========================================================
   // Power-on values
   localparam logic [7:0] CFG_RESET = 8'h08;
   localparam logic [7:0] ST_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] ST2_USED = 8'h3F;
   // ==========================================================
   // Configuration field positions
   localparam int CFG_START = 0;
   localparam int CFG_ALERT_EN = 1;
   localparam int CFG_POL = 2;
   localparam int CFG_HOLD = 3;
   localparam int CFG_PULSE = 4;
   localparam int CFG_INTR_CLR = 5;
   localparam int CFG_SPARE = 6;
   localparam int CFG_INIT = 7;
   // Status 1 and 2 field positions
   localparam int ST1_CHAIN = 7;
   localparam int ST2_HOT = 0;
   localparam int ST2_BOARD = 1;
   localparam int ST2_FAN1 = 2;
   localparam int ST2_FAN2 = 3;
   localparam int ST2_INTR = 4;
   localparam int ST2_OVERHEAT = 5;
   // Fields of registers kept outside this block
   localparam int MASK2_HOT_MODE = 6;
   localparam int MASK2_OVERHEAT_MODE = 7;
   localparam int FDIV_OVERHEAT_EN = 6;
   localparam int FDIV_PULSE_EN = 7;
   // ==========================================================
   // Serial bus and timing
   localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h28;
   localparam int CLK_HZ = 50000000;
   localparam int PULSE_MIN_MS = 10;
   localparam int PULSE_CYCLES = (PULSE_MIN_MS * CLK_HZ + 999) / 1000;
   typedef enum logic [3:0] {
      BUS_IDLE = 4'h0,
      BUS_ADDR = 4'h1,
      BUS_ADDR_ACK = 4'h2,
      BUS_WR = 4'h3,
      BUS_WR_ACK = 4'h4,
      BUS_RD = 4'h5,
      BUS_RD_ACK = 4'h6
   } bus_state_t;
endpackage

// file: sync2.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes the inputs are slow levels; only the second stage is read.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t r_reg, r_next;
   // ==========================================================
   // Stage chain
   always_comb begin
      r_next.s1 = async_in;
      r_next.s2 = r_reg.s1;
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   assign sync_out = r_reg.s2;
endmodule
`default_nettype wire

// file: pulse_timer.sv
// One-shot timer: busy stands for CYCLES clocks after go, then done pulses.
// Assumes go is ignored while busy.
`timescale 1ns/10ps
`default_nettype none
module pulse_timer #(
   parameter int unsigned CYCLES = 500000
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic go,
   output logic busy,
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic busy;
      logic done;
   } tmr_t;
   tmr_t r_reg, r_next;
   // ==========================================================
   // Down counter
   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      if (r_reg.busy) begin
         if (r_reg.cnt == '0) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
         end
      end else if (go) begin
         r_next.busy = 1'b1;
         r_next.cnt = CW'(CYCLES - 1);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   assign busy = r_reg.busy;
   assign done = r_reg.done;
endmodule
`default_nettype wire

// file: monitor_alert.sv
// Configuration, alert status, alert mask and two-wire serial slave of the monitor.
// Assumes comparator events arrive on sys_clk; pins arrive asynchronously.
//
// Contract
// - Start bit one runs scanning and checking; zero means standby.
// - Clearing start leaves a raised alert asserted.
// - Alert enable bit gates the alert pin.
// - Polarity bit: one active-high source drive, zero active-low drain.
// - Hold bit releases alert and reset pins, status frozen.
// - Hold bit halts scanning until written back to zero.
// - Pulse bit drives reset pin low 10 ms when enabled so.
// - Pulse bit clears itself when the pulse ends.
// - Intrusion clear bit drives latch clear, self-clears once pin low.
// - Spare bit sets the spare drive pin level directly.
// - Init bit reloads defaults in all listed registers, reads zero.
// - Status 1 bits 0-6 flag voltage limit violations.
// - Status 1 bit 7 flags low on chained alert input.
// - Hot bit supports one-time or default mode by mask 2 bit 6.
// - Status 2 bit 1 flags board temperature alert input.
// - Status 2 bits 2,3 flag fan 1 and fan 2 limits.
// - Status 2 bit 4 flags intrusion pin gone high.
// - Overheat bit one-time or default by mask 2 bit 7.
// - Mask 1 bits block alert pin, status still records.
// - Reading a status register returns then clears it.
// - 8-bit pointer, zero at reset, selects registers 0 to 3.
`timescale 1ns/10ps
`default_nettype none
module monitor_alert #(
   parameter logic [6:0] BUS_ADDR = monitor_pkg::BUS_ADDR_DEFAULT,
   parameter int unsigned PULSE_CYCLES = monitor_pkg::PULSE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [6:0] voltage_inputs_fault,
   input wire logic fan1_fault,
   input wire logic fan2_fault,
   input wire logic conv_done,
   input wire logic hot_over,
   input wire logic overheat_over,
   input wire logic [7:0] mask2_value,
   input wire logic [7:0] fan_divisor_value,
   input wire logic chain_alert_n,
   input wire logic board_temp_alert_input_n,
   input wire logic intrusion_input,
   output logic alert_out,
   output logic alert_oe,
   output logic reset_or_overheat_pin_out,
   output logic reset_or_overheat_pin_oe,
   output logic intrusion_clear_out,
   output logic intrusion_clear_oe,
   output logic spare_drive_pin,
   output logic scan_enable,
   output logic reinit_pulse
);
   typedef struct packed {
      monitor_pkg::bus_state_t st;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic rw;
      logic first;
      logic [7:0] ptr;
      logic [7:0] cfg;
      logic [7:0] st1;
      logic [7:0] st2;
      logic [7:0] mask1;
      logic hot_prev;
      logic heat_prev;
      logic pulse_run;
      logic scl_d;
      logic sda_d;
      logic sda_oe;
      logic alert_out;
      logic alert_oe;
      logic rst_oe;
      logic intr_oe;
      logic spare;
      logic scan_en;
      logic reinit;
   } mon_t;
   mon_t r_reg, r_next;
   logic [4:0] pins_s;
   logic tmr_busy, tmr_done, pulse_go;
   logic [7:0] clr1, clr2, set1, set2, rd_data;
   logic running, held, wr_cfg_init;
   // ==========================================================
   // Pin synchronisers and pulse timer
   // Idle-high pins enter inverted so cleared stages read as idle, no false edge
   sync2 #(.W(5)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({~scl_in, ~sda_in, ~chain_alert_n, ~board_temp_alert_input_n, intrusion_input}),
      .sync_out(pins_s)
   );
   pulse_timer #(.CYCLES(PULSE_CYCLES)) u_pulse (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .go(pulse_go),
      .busy(tmr_busy),
      .done(tmr_done)
   );
   wire scl_s = ~pins_s[4];
   wire sda_s = ~pins_s[3];
   wire chain_low = pins_s[2];
   wire board_low = pins_s[1];
   wire intr_high = pins_s[0];
   // ==========================================================
   // Register read mux, used for first and later bytes
   function automatic logic [7:0] reg_read(input mon_t s);
      case (s.ptr)
         monitor_pkg::CFG_IDX: reg_read = s.cfg;
         monitor_pkg::ST1_IDX: reg_read = s.st1;
         monitor_pkg::ST2_IDX: reg_read = s.st2;
         monitor_pkg::MASK1_IDX: reg_read = s.mask1;
         default: reg_read = 8'h00;
      endcase
   endfunction
   // Temperature event: default mode every conversion, one-time on crossings
   function automatic logic temp_event(input logic one_time, input logic over,
                                       input logic prev);
      temp_event = conv_done & (one_time ? (over != prev) : over);
   endfunction
   // ==========================================================
   // Main next-state logic
   always_comb begin
      logic scl_rise, scl_fall, bus_start, bus_stop;
      scl_rise = scl_s & ~r_reg.scl_d;
      scl_fall = ~scl_s & r_reg.scl_d;
      bus_start = scl_s & r_reg.scl_d & r_reg.sda_d & ~sda_s;
      bus_stop = scl_s & r_reg.scl_d & ~r_reg.sda_d & sda_s;
      r_next = r_reg;
      r_next.scl_d = scl_s;
      r_next.sda_d = sda_s;
      r_next.reinit = 1'b0;
      clr1 = 8'h00;
      clr2 = 8'h00;
      wr_cfg_init = 1'b0;
      rd_data = reg_read(r_reg);
      running = r_reg.cfg[monitor_pkg::CFG_START] & ~r_reg.cfg[monitor_pkg::CFG_HOLD];
      held = r_reg.cfg[monitor_pkg::CFG_HOLD];
      set1 = running ? {chain_low, voltage_inputs_fault} : 8'h00;
      set2 = 8'h00;
      if (running) begin
         set2[monitor_pkg::ST2_HOT] = temp_event(mask2_value[monitor_pkg::MASK2_HOT_MODE],
                                                 hot_over, r_reg.hot_prev);
         set2[monitor_pkg::ST2_BOARD] = board_low;
         set2[monitor_pkg::ST2_FAN1] = fan1_fault;
         set2[monitor_pkg::ST2_FAN2] = fan2_fault;
         set2[monitor_pkg::ST2_INTR] = intr_high;
         set2[monitor_pkg::ST2_OVERHEAT] = temp_event(
            mask2_value[monitor_pkg::MASK2_OVERHEAT_MODE], overheat_over, r_reg.heat_prev);
         if (conv_done) begin
            r_next.hot_prev = hot_over;
            r_next.heat_prev = overheat_over;
         end
      end
      // Serial slave; start and stop win over any state
      if (bus_start) begin
         r_next.st = monitor_pkg::BUS_ADDR;
         r_next.bit_cnt = 4'h0;
         r_next.sda_oe = 1'b0;
      end else if (bus_stop) begin
         r_next.st = monitor_pkg::BUS_IDLE;
         r_next.sda_oe = 1'b0;
      end else begin
         case (r_reg.st)
            monitor_pkg::BUS_ADDR, monitor_pkg::BUS_WR: begin
               if (scl_rise) begin
                  r_next.shift = {r_reg.shift[6:0], sda_s};
                  r_next.bit_cnt = 4'(r_reg.bit_cnt + 4'h1);
               end else if (scl_fall && r_reg.bit_cnt == 4'h8) begin
                  r_next.bit_cnt = 4'h0;
                  if (r_reg.st == monitor_pkg::BUS_ADDR) begin
                     // Foreign address: stay off the bus until next start
                     r_next.st = (r_reg.shift[7:1] == BUS_ADDR) ? monitor_pkg::BUS_ADDR_ACK
                                                                : monitor_pkg::BUS_IDLE;
                     r_next.sda_oe = (r_reg.shift[7:1] == BUS_ADDR);
                     r_next.rw = r_reg.shift[0];
                     r_next.first = 1'b1;
                  end else begin
                     r_next.st = monitor_pkg::BUS_WR_ACK;
                     r_next.sda_oe = 1'b1;
                     r_next.first = 1'b0;
                     // First written byte is the pointer
                     if (r_reg.first) begin
                        r_next.ptr = r_reg.shift;
                     end else if (r_reg.ptr == monitor_pkg::CFG_IDX) begin
                        r_next.cfg = r_reg.shift & 8'h7F;
                        wr_cfg_init = r_reg.shift[monitor_pkg::CFG_INIT];
                     end else if (r_reg.ptr == monitor_pkg::MASK1_IDX) begin
                        r_next.mask1 = r_reg.shift;
                     end
                  end
               end
            end
            monitor_pkg::BUS_WR_ACK: begin
               if (scl_fall) begin
                  r_next.st = monitor_pkg::BUS_WR;
                  r_next.sda_oe = 1'b0;
               end
            end
            monitor_pkg::BUS_ADDR_ACK, monitor_pkg::BUS_RD_ACK: begin
               if (scl_rise && r_reg.st == monitor_pkg::BUS_RD_ACK) begin
                  r_next.first = sda_s;
               end else if (scl_fall) begin
                  if (r_reg.rw && !(r_reg.st == monitor_pkg::BUS_RD_ACK && r_reg.first)) begin
                     r_next.st = monitor_pkg::BUS_RD;
                     r_next.shift = rd_data;
                     r_next.sda_oe = ~rd_data[7];
                     clr1 = (r_reg.ptr == monitor_pkg::ST1_IDX) ? 8'hFF : 8'h00;
                     clr2 = (r_reg.ptr == monitor_pkg::ST2_IDX) ? 8'hFF : 8'h00;
                  end else begin
                     r_next.st = r_reg.rw ? monitor_pkg::BUS_IDLE : monitor_pkg::BUS_WR;
                     r_next.sda_oe = 1'b0;
                  end
                  r_next.bit_cnt = 4'h0;
               end
            end
            monitor_pkg::BUS_RD: begin
               if (scl_rise) begin
                  r_next.bit_cnt = 4'(r_reg.bit_cnt + 4'h1);
               end else if (scl_fall) begin
                  if (r_reg.bit_cnt == 4'h8) begin
                     r_next.st = monitor_pkg::BUS_RD_ACK;
                     r_next.sda_oe = 1'b0;
                  end else begin
                     r_next.shift = {r_reg.shift[6:0], 1'b0};
                     r_next.sda_oe = ~r_reg.shift[6];
                  end
               end
            end
            default: begin
               r_next.sda_oe = 1'b0;
            end
         endcase
      end
      // Hold freezes status; an event during a read clear still wins
      if (held) begin
         r_next.st1 = r_reg.st1 & ~clr1;
         r_next.st2 = r_reg.st2 & ~clr2;
      end else begin
         r_next.st1 = (r_reg.st1 & ~clr1) | set1;
         r_next.st2 = ((r_reg.st2 & ~clr2) | set2) & monitor_pkg::ST2_USED;
      end
      // Pulse bit clears when the pulse ends
      if (tmr_done) begin
         r_next.cfg[monitor_pkg::CFG_PULSE] = 1'b0;
         r_next.pulse_run = 1'b0;
      end
      // Launch reset pulse only in pulse mode
      pulse_go = r_reg.cfg[monitor_pkg::CFG_PULSE] & ~r_reg.pulse_run
                 & fan_divisor_value[monitor_pkg::FDIV_PULSE_EN]
                 & ~fan_divisor_value[monitor_pkg::FDIV_OVERHEAT_EN];
      if (pulse_go) begin
         r_next.pulse_run = 1'b1;
      end
      // Clear bit drops once the intrusion pin reads low
      if (r_reg.intr_oe && !intr_high) begin
         r_next.cfg[monitor_pkg::CFG_INTR_CLR] = 1'b0;
      end
      // Reload defaults; status 1 events in this cycle still land, status 2 events are lost
      if (wr_cfg_init) begin
         r_next.cfg = monitor_pkg::CFG_RESET;
         r_next.st1 = monitor_pkg::ST_RESET | set1;
         r_next.st2 = monitor_pkg::ST_RESET;
         r_next.mask1 = monitor_pkg::MASK_RESET;
         r_next.reinit = 1'b1;
      end
      // Alert drive from unmasked pending status
      // Status is sticky, so clearing start keeps the alert
      r_next.alert_oe = r_reg.cfg[monitor_pkg::CFG_ALERT_EN] & ~held
                        & (|(r_reg.st1 & ~r_reg.mask1)
                           | |(r_reg.st2 & ~mask2_value & monitor_pkg::ST2_USED));
      r_next.alert_out = r_reg.cfg[monitor_pkg::CFG_POL];
      // Hold releases the reset pin too
      r_next.rst_oe = ~held & (tmr_busy | (fan_divisor_value[monitor_pkg::FDIV_OVERHEAT_EN]
                      & ~fan_divisor_value[monitor_pkg::FDIV_PULSE_EN]
                      & r_reg.st2[monitor_pkg::ST2_OVERHEAT]));
      r_next.intr_oe = r_reg.cfg[monitor_pkg::CFG_INTR_CLR];
      r_next.spare = r_reg.cfg[monitor_pkg::CFG_SPARE];
      r_next.scan_en = running;
   end
   // ==========================================================
   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.st <= monitor_pkg::BUS_IDLE;
         r_reg.ptr <= monitor_pkg::PTR_RESET;
         r_reg.cfg <= monitor_pkg::CFG_RESET;
         r_reg.scl_d <= 1'b1;
         r_reg.sda_d <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end
   // Open-drain pins only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe = r_reg.sda_oe;
   assign alert_out = r_reg.alert_out;
   assign alert_oe = r_reg.alert_oe;
   assign reset_or_overheat_pin_out = 1'b0;
   assign reset_or_overheat_pin_oe = r_reg.rst_oe;
   assign intrusion_clear_out = 1'b0;
   assign intrusion_clear_oe = r_reg.intr_oe;
   assign spare_drive_pin = r_reg.spare;
   assign scan_enable = r_reg.scan_en;
   assign reinit_pulse = r_reg.reinit;
   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence pulse_launch;
      pulse_go ##1 r_reg.pulse_run;
   endsequence
   sequence pulse_end;
      tmr_done ##1 !r_reg.cfg[monitor_pkg::CFG_PULSE];
   endsequence
   chk_alert_gate_off: assert property (!r_reg.cfg[1] |=> !alert_oe)
      else $error("alert driven while disabled");
   chk_alert_polarity: assert property (alert_oe |-> alert_out == $past(r_reg.cfg[2]))
      else $error("alert level not the selected polarity");
   chk_hold_quiet_pins: assert property (held |=> !alert_oe && !reset_or_overheat_pin_oe)
      else $error("pins driven during hold");
   chk_hold_status_frozen: assert property (held && clr1 == 8'h00 && !wr_cfg_init
      |=> r_reg.st1 == $past(r_reg.st1))
      else $error("status changed during hold");
   chk_spare_level: assert property (##1 spare_drive_pin == $past(r_reg.cfg[6]))
      else $error("spare pin not following its bit");
   chk_init_reload: assert property (wr_cfg_init |=> r_reg.cfg == 8'h08
      && r_reg.mask1 == 8'h00 && reinit_pulse)
      else $error("defaults not reloaded");
   chk_read_clears_status: assert property (clr1 == 8'hFF && set1 == 8'h00 && !held
      |=> r_reg.st1 == 8'h00)
      else $error("status survived a read");
   chk_mask_blocks_alert: assert property ((r_reg.st1 & ~r_reg.mask1) == 8'h00
      && (r_reg.st2 & ~mask2_value & 8'h3F) == 8'h00 |=> !alert_oe)
      else $error("alert from masked status");
   chk_pulse_holds_low: assert property (pulse_launch ##2 !held |-> reset_or_overheat_pin_oe[*8])
      else $error("reset pulse too short");
   chk_pulse_self_clear: assert property (tmr_done |-> pulse_end)
      else $error("pulse bit not cleared");
   chk_standby_no_set: assert property (!r_reg.cfg[0] && clr1 == 8'h00 && !wr_cfg_init
      |=> r_reg.st1 == $past(r_reg.st1))
      else $error("status set in standby");
endmodule
`default_nettype wire

// file: placeholder_end.sv
// Intentionally empty compilation unit.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: bus_host.sv
// Two-wire bus master standing in for the host processor.
// Assumes the device pulls SDA low through sda_oe and the line has a pull-up.
`timescale 1ns/10ps
`default_nettype none
module bus_host (
   input wire logic sys_clk,
   input wire logic sda_oe,
   output logic scl,
   output wire logic sda_line
);
   logic sda_rel = 1'b1;
   int nak = 0;
   // Open drain: a released line shows the pull-up level
   assign sda_line = sda_rel & ~sda_oe;
   initial scl = 1'b1;
   // ==========================================
   // Bus phases
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Six-clock phases keep above the four-clock minimum of the synchronisers
   task automatic bit_io(input logic b, output logic r);
      sda_rel <= b;
      tick(6);
      scl <= 1'b1;
      tick(6);
      r = sda_line;
      scl <= 1'b0;
      tick(1);
   endtask
   // Also serves as repeated start, since it first releases SDA with SCL low
   task automatic start();
      sda_rel <= 1'b1;
      tick(6);
      scl <= 1'b1;
      tick(6);
      sda_rel <= 1'b0;
      tick(6);
      scl <= 1'b0;
      tick(1);
   endtask
   task automatic stop();
      sda_rel <= 1'b0;
      tick(6);
      scl <= 1'b1;
      tick(6);
      sda_rel <= 1'b1;
      tick(6);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(mack, ack);
   endtask
   // Written byte; a missing acknowledge is counted
   task automatic wbyte(input logic [7:0] tx);
      logic [7:0] rx;
      logic a;
      xfer(tx, 1'b1, rx, a);
      if (a !== 1'b0) nak++;
   endtask
   // ==========================================
   // Register cycles
   task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
      start();
      wbyte(8'h50);
      wbyte(p);
      wbyte(d);
      stop();
   endtask
   // One byte, closed by NACK so the device lets go of SDA before stop
   task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
      logic a;
      start();
      wbyte(8'h50);
      wbyte(p);
      start();
      wbyte(8'h51);
      xfer(8'hFF, 1'b1, d, a);
      stop();
   endtask
endmodule
`default_nettype wire

// file: monitor_alert_tb.sv
// Self-checking bench of the monitor configuration and alert logic.
// Assumes bus_host as host; pulse shortened to 20 clocks.
`timescale 1ns/10ps
`default_nettype none
module monitor_alert_tb;
   localparam int PULSE = 20;
   logic sys_clk, rst_n = 1'b0, conv = 1'b0, hot = 1'b0, ovh = 1'b0, f1 = 1'b0, f2 = 1'b0;
   logic chain_n = 1'b1, board_n = 1'b1, intr = 1'b0;
   logic [6:0] vflt = 7'h00;
   logic [7:0] m2 = 8'h00, fdiv = 8'h00, d;
   logic scl, sda, sda_oe, alert_out, alert_oe, rst_oe, iclr_oe, spare, scan_en, reinit;
   int failures = 0, n_checks = 0, plen = 0, ninit = 0, nclr = 0;
   bus_host host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda_line(sda));
   monitor_alert #(.PULSE_CYCLES(PULSE)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .voltage_inputs_fault(vflt),
      .fan1_fault(f1), .fan2_fault(f2), .conv_done(conv), .hot_over(hot),
      .overheat_over(ovh), .mask2_value(m2), .fan_divisor_value(fdiv),
      .chain_alert_n(chain_n), .board_temp_alert_input_n(board_n), .intrusion_input(intr),
      .alert_out(alert_out), .alert_oe(alert_oe), .reset_or_overheat_pin_out(),
      .reset_or_overheat_pin_oe(rst_oe), .intrusion_clear_out(), .intrusion_clear_oe(iclr_oe),
      .spare_drive_pin(spare), .scan_enable(scan_en), .reinit_pulse(reinit));
   // ==========================================
   // Clock and pin activity counters
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (rst_oe === 1'b1) plen++;
      if (reinit === 1'b1) ninit++;
      if (iclr_oe === 1'b1) nclr++;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset();
      host.read_reg(8'h00, d);
      chk("cfg", d, 8'h08);
      host.read_reg(8'h03, d);
      chk("mask1", d, 8'h00);
      host.read_reg(8'h04, d);
      chk("unmapped", d, 8'h00);
      chk("scan_rst", 8'(scan_en), 8'h00);
   endtask
   task automatic t_alert();
      host.write_reg(8'h00, 8'h03);
      chk("scan_on", 8'(scan_en), 8'h01);
      vflt <= 7'h45;
      cyc(1);
      vflt <= 7'h00;
      cyc(4);
      chk("alert_oe", 8'(alert_oe), 8'h01);
      chk("alert_low", 8'(alert_out), 8'h00);
      host.write_reg(8'h00, 8'h02);
      chk("alert_kept", 8'(alert_oe), 8'h01);
      // Standby: this event must not reach the status
      vflt <= 7'h02;
      cyc(1);
      vflt <= 7'h00;
      cyc(4);
      host.read_reg(8'h01, d);
      chk("st1", d, 8'h45);
      chk("alert_rel", 8'(alert_oe), 8'h00);
      // No event between reads stands in for the refresh wait
      host.read_reg(8'h01, d);
      chk("st1_clr", d, 8'h00);
   endtask
   // Mask first, then start, as a careful host would
   task automatic t_mask();
      host.write_reg(8'h03, 8'h80);
      host.write_reg(8'h00, 8'h03);
      chain_n <= 1'b0;
      cyc(6);
      chain_n <= 1'b1;
      cyc(6);
      chk("alert_mask", 8'(alert_oe), 8'h00);
      host.read_reg(8'h01, d);
      chk("st1_chain", d, 8'h80);
      host.write_reg(8'h00, 8'h01);
      vflt <= 7'h01;
      cyc(1);
      vflt <= 7'h00;
      cyc(4);
      chk("alert_gate", 8'(alert_oe), 8'h00);
      host.read_reg(8'h01, d);
      chk("st1_in0", d, 8'h01);
   endtask
   task automatic t_st2();
      host.write_reg(8'h00, 8'h07);
      {f1, f2, hot, ovh, conv, board_n, intr} <= 7'h7D;
      cyc(1);
      {f1, f2, conv} <= 3'h0;
      cyc(5);
      {board_n, intr} <= 2'h2;
      cyc(6);
      chk("alert_high", {alert_oe, alert_out}, 8'h03);
      host.read_reg(8'h02, d);
      chk("st2", d, 8'h3F);
      // One-time mode: a still-hot conversion must not set the bits again
      m2 <= 8'hC0;
      conv <= 1'b1;
      cyc(1);
      conv <= 1'b0;
      cyc(3);
      host.read_reg(8'h02, d);
      chk("st2_once", d, 8'h00);
      {hot, ovh, m2} <= 10'h000;
   endtask
   // Alert and overheat drive pending first, so hold has pins to release
   task automatic t_hold();
      fdiv <= 8'h40;
      host.write_reg(8'h00, 8'h03);
      {vflt, ovh, conv} <= 9'h007;
      cyc(1);
      {vflt, ovh, conv} <= 9'h000;
      cyc(4);
      chk("pins_on", {alert_oe, rst_oe}, 8'h03);
      host.write_reg(8'h00, 8'h0B);
      chk("scan_hold", 8'(scan_en), 8'h00);
      chk("alert_hold", {alert_oe, rst_oe}, 8'h00);
      vflt <= 7'h7F;
      cyc(1);
      vflt <= 7'h00;
      cyc(4);
      host.read_reg(8'h01, d);
      chk("st1_frozen", d, 8'h01);
      host.write_reg(8'h00, 8'h01);
      chk("scan_resume", 8'(scan_en), 8'h01);
      host.read_reg(8'h02, d);
      chk("st2_kept", d, 8'h20);
      fdiv <= 8'h00;
   endtask
   task automatic t_pulse();
      host.write_reg(8'h00, 8'h10);
      host.read_reg(8'h00, d);
      chk("pulse_off", {d, 8'(plen)}, 16'h1000);
      host.write_reg(8'h00, 8'h00);
      fdiv <= 8'h80;
      host.write_reg(8'h00, 8'h10);
      cyc(2 * PULSE);
      host.read_reg(8'h00, d);
      chk("pulse_clr", d, 8'h00);
      chk("pulse_len", 8'(plen >= PULSE), 8'h01);
   endtask
   task automatic t_init();
      host.write_reg(8'h03, 8'hFF);
      host.write_reg(8'h00, 8'h60);
      cyc(4);
      chk("spare", 8'(spare), 8'h01);
      host.read_reg(8'h00, d);
      chk("clr_self", {d, 8'(nclr > 0)}, 16'h4001);
      host.write_reg(8'h00, 8'hC0);
      host.read_reg(8'h00, d);
      chk("init_cfg", d, 8'h08);
      host.read_reg(8'h03, d);
      chk("init_mask", {d, 8'(ninit), 8'(spare)}, 24'h000100);
   endtask
   // ==========================================
   // Verdict, watchdog and main sequence
   task automatic report_and_stop();
      $display("checks %0d failures %0d nak %0d", n_checks, failures, host.nak);
      if (failures == 0 && n_checks > 0 && host.nak == 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // About 30,000 clocks, twice the expected length of the run
   initial begin
      #600000;
      failures++;
      report_and_stop();
   end
   initial begin
      cyc(3);
      rst_n <= 1'b1;
      cyc(1);
      t_reset();
      t_alert();
      t_mask();
      t_st2();
      t_pulse();
      t_hold();
      t_init();
      report_and_stop();
   end
endmodule
`default_nettype wire
